// ==== hw/sad_pkg.sv ====
// Purpose : shared types and address map of the system address decoder
// Assumes : 32-bit byte addresses from a single processor requester
// Notes   : peripheral windows list only what the decoder must police
package sad_pkg;

  localparam int DATA_W    = 32;
  localparam int PIDX_W    = 5;
  localparam int NUM_PERIPH = 22;

  // ==========================================================================
  // enumerations
  typedef enum logic [3:0] {
    TGT_NONE, TGT_FLASH, TGT_SYSMEM, TGT_UID, TGT_OPTB, TGT_FACTORY,
    TGT_SRAM, TGT_AHB, TGT_APB, TGT_IOPORT
  } sad_target_t;

  typedef enum logic [1:0] {BOOT_FLASH, BOOT_SYSMEM, BOOT_SRAM, BOOT_SPARE} sad_boot_t;
  typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD, SZ_BAD} sad_size_t;
  typedef enum logic [1:0] {WC_WORD, WC_WORD_HALF, WC_ANY} sad_width_t;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic              valid;
    logic              write;
    sad_size_t         size;
    logic [31:0]       addr;
    logic [DATA_W-1:0] wdata;
  } sad_req_t;

  typedef struct packed {
    logic              done;
    logic              err;
    logic [DATA_W-1:0] rdata;
  } sad_rsp_t;

  typedef struct packed {
    logic              valid;
    sad_target_t       target;
    logic [PIDX_W-1:0] periph;
    logic              write;
    sad_size_t         size;
    logic [31:0]       offset;
    logic [DATA_W-1:0] wdata;
  } sad_tgt_req_t;

  typedef struct packed {
    logic              ready;
    logic              err;
    logic [DATA_W-1:0] rdata;
  } sad_tgt_rsp_t;

  // ==========================================================================
  // memory regions
  localparam logic [31:0] ALIAS_LAST   = 32'h0000_FFFF;
  localparam logic [31:0] FLASH_BASE   = 32'h0800_0000;
  localparam logic [31:0] FLASH_LAST   = 32'h0800_FFFF;
  localparam logic [31:0] SYSMEM_BASE  = 32'h1FFF_0000;
  localparam logic [31:0] SYSMEM_LAST  = 32'h1FFF_0DFF;
  localparam logic [31:0] UID_BASE     = 32'h1FFF_0E00;
  localparam logic [31:0] UID_LAST     = 32'h1FFF_0E7F;
  localparam logic [31:0] OPTB_BASE    = 32'h1FFF_0E80;
  localparam logic [31:0] OPTB_LAST    = 32'h1FFF_0EFF;
  localparam logic [31:0] FACT_BASE    = 32'h1FFF_0F00;
  localparam logic [31:0] FACT_LAST    = 32'h1FFF_0F7F;
  localparam logic [31:0] SRAM_BASE    = 32'h2000_0000;
  localparam logic [31:0] SRAM_LAST    = 32'h2000_1FFF;
  localparam logic [31:0] APB_BASE     = 32'h4000_0000;
  localparam logic [31:0] APB_LAST     = 32'h4001_FFFF;
  localparam logic [31:0] AHB_BASE     = 32'h4002_0000;
  localparam logic [31:0] AHB_LAST     = 32'h4FFF_FFFF;
  localparam logic [31:0] IOPORT_BASE  = 32'h5000_0000;
  localparam logic [31:0] IOPORT_LAST  = 32'h5000_17FF;
  localparam logic [31:0] RDATA_RESET  = 32'h0000_0000;

  // ==========================================================================
  // populated peripheral windows
  localparam logic [PIDX_W-1:0] PERIPH_EXTERNAL_INTERRUPT_CONTROLLER = 5'h02;
  localparam logic [PIDX_W-1:0] PERIPH_CLK  = 5'h03;
  localparam logic [PIDX_W-1:0] PERIPH_PWR  = 5'h0F;
  localparam logic [PIDX_W-1:0] PERIPH_RTC  = 5'h13;

  localparam logic [31:0] PERIPH_BASE [NUM_PERIPH] = '{
    32'h4002_3000, 32'h4002_2000, 32'h4002_1800, 32'h4002_1000, 32'h4002_0000,
    32'h4001_5800, 32'h4001_4800, 32'h4001_4400, 32'h4001_3800, 32'h4001_3000,
    32'h4001_2C00, 32'h4001_2400, 32'h4001_0200, 32'h4001_0000, 32'h4000_7C00,
    32'h4000_7000, 32'h4000_5400, 32'h4000_3000, 32'h4000_2C00, 32'h4000_2800,
    32'h4000_2000, 32'h4000_0400};
  localparam logic [31:0] PERIPH_LAST [NUM_PERIPH] = '{
    32'h4002_3008, 32'h4002_2120, 32'h4002_1884, 32'h4002_1060, 32'h4002_003C,
    32'h4001_587F, 32'h4001_484C, 32'h4001_444C, 32'h4001_3818, 32'h4001_300C,
    32'h4001_2C4C, 32'h4001_2708, 32'h4001_021F, 32'h4001_01FF, 32'h4000_7C24,
    32'h4000_7014, 32'h4000_5430, 32'h4000_3010, 32'h4000_2C08, 32'h4000_282C,
    32'h4000_2050, 32'h4000_044C};
  localparam sad_width_t PERIPH_WIDTH [NUM_PERIPH] = '{
    WC_WORD, WC_WORD, WC_ANY, WC_ANY, WC_WORD,
    WC_WORD, WC_WORD, WC_WORD, WC_WORD, WC_WORD,
    WC_WORD, WC_WORD, WC_WORD, WC_WORD, WC_WORD,
    WC_WORD_HALF, WC_WORD, WC_WORD, WC_WORD, WC_WORD_HALF,
    WC_WORD, WC_WORD};

endpackage

// ==== hw/sad_periph_lookup.sv ====
// Purpose : find which populated peripheral window holds an address
// Assumes : windows in the table never overlap
// Notes   : purely combinational, lowest index wins
`timescale 1ns/100ps
module sad_periph_lookup #(
  parameter int N = sad_pkg::NUM_PERIPH
) (
  input  wire logic [31:0]                i_addr,
  output logic                            o_hit,
  output logic [sad_pkg::PIDX_W-1:0]      o_idx,
  output sad_pkg::sad_width_t             o_width
);
  import sad_pkg::*;

  logic [N-1:0] match;

  // ==========================================================================
  // window compare
  for (genvar g = 0; g < N; g++) begin : g_win
    assign match[g] = (i_addr >= PERIPH_BASE[g]) && (i_addr <= PERIPH_LAST[g]);
  end

  always_comb begin
    o_hit   = 1'b0;
    o_idx   = '0;
    o_width = WC_WORD;
    for (int i = N - 1; i >= 0; i--) begin
      if (match[i]) begin
        o_hit   = 1'b1;
        o_idx   = PIDX_W'(i);
        o_width = PERIPH_WIDTH[i];
      end
    end
  end

endmodule

// ==== hw/sad_width_gate.sv ====
// Purpose : decide whether an access size is accepted by a width class
// Assumes : size code SZ_BAD is never legal
// Notes   : combinational
`timescale 1ns/100ps
module sad_width_gate (
  input  wire sad_pkg::sad_size_t  i_size,
  input  wire sad_pkg::sad_width_t i_class,
  output logic                     o_ok
);
  import sad_pkg::*;

  function automatic logic size_ok(input sad_size_t s, input sad_width_t c);
    logic r;
    r = 1'b0;
    unique case (c)
      WC_ANY:       r = (s != SZ_BAD);
      WC_WORD_HALF: r = (s == SZ_WORD) || (s == SZ_HALF);
      WC_WORD:      r = (s == SZ_WORD);
      default:      r = 1'b0;
    endcase
    return r;
  endfunction

  // ==========================================================================
  // width check
  assign o_ok = size_ok(i_size, i_class);

endmodule

// ==== hw/sad_decoder.sv ====
// Purpose : system address decoder between the processor and its targets
// Assumes : requester holds i_req until o_rsp.done; targets answer on ready
// Notes   : one request in flight; every answer is a one-cycle done pulse
`timescale 1ns/100ps
module sad_decoder (
  input  wire logic                  i_mclk,
  input  wire logic                  i_rst,
  input  wire sad_pkg::sad_boot_t    i_boot_cfg,
  input  wire sad_pkg::sad_req_t     i_req,
  input  wire sad_pkg::sad_tgt_rsp_t i_tgt_rsp,
  output sad_pkg::sad_tgt_req_t      o_tgt,
  output sad_pkg::sad_rsp_t          o_rsp
);
  import sad_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_ACCESS, ST_RESP} sad_state_t;

  sad_state_t        state_reg;
  sad_state_t        state_next;
  logic [31:0]       phys;
  sad_target_t       dec_tgt;
  logic [31:0]       dec_off;
  logic              dec_rsv;
  logic              dec_quiet;
  logic              p_hit;
  logic [PIDX_W-1:0] p_idx;
  sad_width_t        p_width;
  logic              width_ok;
  logic              take;
  logic              tgt_done;

  function automatic logic in_rng(input logic [31:0] a, input logic [31:0] lo,
                                  input logic [31:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  // ==========================================================================
  // boot alias
  // alias translate
  always_comb begin
    phys = i_req.addr;
    if (i_req.addr <= ALIAS_LAST) begin
      unique case (i_boot_cfg)
        BOOT_SYSMEM: phys = SYSMEM_BASE | i_req.addr;
        BOOT_SRAM:   phys = SRAM_BASE | i_req.addr;
        default:     phys = FLASH_BASE | i_req.addr;
      endcase
    end
  end

  sad_periph_lookup u_lookup (
    .i_addr  (phys),
    .o_hit   (p_hit),
    .o_idx   (p_idx),
    .o_width (p_width)
  );

  // non-peripheral targets take any legal size
  sad_width_gate u_width (
    .i_size  (i_req.size),
    .i_class (p_hit ? p_width : WC_ANY),
    .o_ok    (width_ok)
  );

  // ==========================================================================
  // region decode
  // gaps inside the peripheral windows are reserved; the bus decides the fault
  always_comb begin
    dec_tgt   = TGT_NONE;
    dec_off   = '0;
    dec_quiet = 1'b0;
    if (in_rng(phys, UID_BASE, UID_LAST)) begin
      dec_tgt = TGT_UID;
      dec_off = phys - UID_BASE;
    end else if (in_rng(phys, OPTB_BASE, OPTB_LAST)) begin
      dec_tgt = TGT_OPTB;
      dec_off = phys - OPTB_BASE;
    end else if (in_rng(phys, FACT_BASE, FACT_LAST)) begin
      dec_tgt = TGT_FACTORY;
      dec_off = phys - FACT_BASE;
    end else if (in_rng(phys, SYSMEM_BASE, SYSMEM_LAST)) begin
      dec_tgt = TGT_SYSMEM;
      dec_off = phys - SYSMEM_BASE;
    end else if (in_rng(phys, FLASH_BASE, FLASH_LAST)) begin
      dec_tgt = TGT_FLASH;
      dec_off = phys - FLASH_BASE;
    end else if (in_rng(phys, SRAM_BASE, SRAM_LAST)) begin
      dec_tgt = TGT_SRAM;
      dec_off = phys - SRAM_BASE;
    end else if (in_rng(phys, IOPORT_BASE, IOPORT_LAST)) begin
      dec_tgt = TGT_IOPORT;
      dec_off = phys - IOPORT_BASE;
    end else if (p_hit) begin
      dec_tgt = in_rng(phys, APB_BASE, APB_LAST) ? TGT_APB : TGT_AHB;
      dec_off = phys - PERIPH_BASE[p_idx];
    end
    dec_quiet = in_rng(phys, APB_BASE, APB_LAST);
  end

  // width class refuses the access like a reserved address
  assign dec_rsv  = (dec_tgt == TGT_NONE) || !width_ok;
  assign take     = (state_reg == ST_IDLE) && i_req.valid;
  assign tgt_done = (state_reg == ST_ACCESS) && i_tgt_rsp.ready;

  // ==========================================================================
  // sequencing
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (take) begin
          state_next = dec_rsv ? ST_RESP : ST_ACCESS;
        end
      end
      ST_ACCESS: begin
        if (i_tgt_rsp.ready) begin
          state_next = ST_RESP;
        end
      end
      ST_RESP: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================================
  // target request
  // reserved never strobes a target
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_tgt <= '0;
    end else if (take && !dec_rsv) begin
      o_tgt.valid  <= 1'b1;
      o_tgt.target <= dec_tgt;
      o_tgt.periph <= p_hit ? p_idx : '0;
      o_tgt.write  <= i_req.write;
      o_tgt.size   <= i_req.size;
      o_tgt.offset <= dec_off;
      o_tgt.wdata  <= i_req.wdata;
    end else if (tgt_done) begin
      o_tgt.valid <= 1'b0;
    end
  end

  // ==========================================================================
  // response
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_rsp <= '0;
    end else if (take && dec_rsv) begin
      o_rsp.done  <= 1'b1;
      o_rsp.err   <= !dec_quiet;
      o_rsp.rdata <= RDATA_RESET;
    end else if (tgt_done) begin
      o_rsp.done  <= 1'b1;
      o_rsp.err   <= i_tgt_rsp.err;
      o_rsp.rdata <= i_tgt_rsp.rdata;
    end else begin
      o_rsp.done <= 1'b0;
    end
  end

  // ==========================================================================
  // checks
  // all checks live in the one clock domain; reset parks them
  default clocking cb @(posedge i_mclk);
  endclocking

  default disable iff (i_rst);

  sequence s_rsv_take;
    take && dec_rsv;
  endsequence

  sequence s_tgt_take;
    take && !dec_rsv;
  endsequence

  sequence s_rsv_answer;
    o_rsp.done && (o_rsp.rdata == RDATA_RESET) && !o_tgt.valid;
  endsequence

  sequence s_tgt_wait;
    o_tgt.valid && !i_tgt_rsp.ready;
  endsequence

  a_rsv_zero: assert property (s_rsv_take |=> s_rsv_answer)
    else $error("reserved access did not answer zero");

  a_rsv_notgt: assert property (s_rsv_take |=> !o_tgt.valid)
    else $error("reserved access reached a target");

  a_hs_fault: assert property (s_rsv_take ##0 !dec_quiet |=> o_rsp.err)
    else $error("high-speed reserved access gave no fault");

  a_pb_quiet: assert property (s_rsv_take ##0 dec_quiet |=> !o_rsp.err)
    else $error("peripheral reserved access raised a fault");

  a_rsv_done: assert property (s_rsv_take |=> s_rsv_answer ##1 !o_rsp.done)
    else $error("reserved access did not end at once");

  a_done_pulse: assert property (o_rsp.done |=> !o_rsp.done)
    else $error("done held longer than one cycle");

  a_tgt_held: assert property (s_tgt_wait |=> $stable(o_tgt))
    else $error("target request changed before ready");

  a_tgt_strobe: assert property (s_tgt_take |=> o_tgt.valid)
    else $error("routed access did not strobe a target");

  a_pass_data: assert property (tgt_done |=> o_rsp.done && o_rsp.rdata == $past(i_tgt_rsp.rdata))
    else $error("target read data not passed on");

  a_sram_top: assert property (take && phys[31:30] == 2'b00 && phys > SRAM_LAST |-> dec_rsv)
    else $error("address above sram was not reserved");

  a_alias_fl: assert property (take && i_req.addr <= ALIAS_LAST && i_boot_cfg == BOOT_FLASH
                               |-> dec_tgt == TGT_FLASH)
    else $error("alias did not select flash");

  a_alias_sys: assert property (take && i_boot_cfg == BOOT_SYSMEM
                                && i_req.addr <= SYSMEM_LAST - SYSMEM_BASE
                                |-> dec_tgt == TGT_SYSMEM)
    else $error("alias did not select system memory");

  a_alias_ram: assert property (take && i_boot_cfg == BOOT_SRAM
                                && i_req.addr <= SRAM_LAST - SRAM_BASE
                                |-> dec_tgt == TGT_SRAM)
    else $error("alias did not select sram");

  a_uid_valid: assert property (take && in_rng(phys, UID_BASE, UID_LAST)
                                |-> dec_tgt == TGT_UID)
    else $error("identifier block not decoded");

  a_optb_valid: assert property (take && in_rng(phys, OPTB_BASE, OPTB_LAST)
                                 |-> dec_tgt == TGT_OPTB)
    else $error("option bytes not decoded");

  a_fact_valid: assert property (take && in_rng(phys, FACT_BASE, FACT_LAST)
                                 |-> dec_tgt == TGT_FACTORY)
    else $error("factory region not decoded");

  a_width_any: assert property (take && p_hit && (p_idx == PERIPH_EXTERNAL_INTERRUPT_CONTROLLER || p_idx == PERIPH_CLK)
                                && i_req.size != SZ_BAD |-> !dec_rsv)
    else $error("controller refused a legal width");

  a_width_half: assert property (take && p_hit && (p_idx == PERIPH_PWR || p_idx == PERIPH_RTC)
                                 && i_req.size == SZ_HALF |-> !dec_rsv)
    else $error("halfword access refused");

  a_width_byte: assert property (take && p_hit && (p_idx == PERIPH_PWR || p_idx == PERIPH_RTC)
                                 && i_req.size == SZ_BYTE |-> dec_rsv)
    else $error("byte access accepted");

endmodule

// ==== verification/sad_target_model.sv ====
// Purpose : behavioural memories and peripherals behind the decoder
// Assumes : one request at a time, held until ready
// Notes   : read data carries the target code so routing shows in reads
`timescale 1ns/100ps
module sad_target_model (
  input  wire logic                  i_mclk,
  input  wire logic                  i_rst,
  input  wire logic [1:0]            i_delay,
  input  wire sad_pkg::sad_tgt_req_t i_tgt,
  output sad_pkg::sad_tgt_rsp_t      o_rsp
);
  import sad_pkg::*;
  // ==========================================================================
  // answer timing
  logic        busy_reg;
  logic        rest_reg;
  logic [1:0]  wait_reg;
  logic [31:0] noise_reg;
  sad_target_t tgt_reg;

  // one rest cycle after ready, so a request still held is not taken twice
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      busy_reg <= 1'b0;
      rest_reg <= 1'b0;
      wait_reg <= 2'h0;
      tgt_reg  <= TGT_NONE;
    end else if (i_tgt.valid && !busy_reg && !rest_reg) begin
      busy_reg <= 1'b1;
      wait_reg <= i_delay;
      tgt_reg  <= i_tgt.target;
    end else if (busy_reg && wait_reg != 2'h0) begin
      wait_reg <= wait_reg - 2'h1;
    end else if (busy_reg) begin
      busy_reg <= 1'b0;
      rest_reg <= 1'b1;
    end else begin
      rest_reg <= 1'b0;
    end
  end

  // data lines change every cycle outside ready, never hold a stale value
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      noise_reg <= 32'h1357_9BDF;
    end else begin
      noise_reg <= {noise_reg[30:0], ~noise_reg[31]};
    end
  end

  always_comb begin
    o_rsp.ready = busy_reg && (wait_reg == 2'h0);
    o_rsp.err   = 1'b0;
    o_rsp.rdata = o_rsp.ready ? (32'hC3A5_0000 | {28'h0, tgt_reg}) : noise_reg;
  end
endmodule

// ==== verification/system_address_decoder_tb.sv ====
// Purpose : self-checking bench of the system address decoder
// Assumes : requester holds its request until the one-cycle done pulse
// Notes   : width-refused accesses are checked for routing and data only
`timescale 1ns/100ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin n_errors++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp); end end
module system_address_decoder_tb;
  import sad_pkg::*;
  typedef struct packed {
    logic        routed;
    sad_target_t tgt;
    logic        err;
    logic        care;
  } sad_exp_t;
  // ==========================================================================
  // signals
  logic         mclk = 1'b0;
  logic         rst;
  logic [1:0]   dly;
  sad_boot_t    boot;
  sad_req_t     req;
  sad_rsp_t     rsp;
  sad_tgt_req_t tgt_req;
  sad_tgt_rsp_t tgt_rsp;
  logic [31:0]  seed = 32'h86DF_EFDB;
  int           n_errors = 0;
  int           n_checks = 0;
  logic         abort = 1'b0;
  localparam logic [31:0] CORNER [14] = '{SRAM_LAST - 32'h3, SRAM_LAST + 32'h1,
    UID_BASE, UID_LAST - 32'h3, OPTB_BASE, FACT_BASE, FACT_LAST - 32'h3,
    FACT_LAST + 32'h1, SYSMEM_LAST - 32'h3, 32'h1FFF_1000, 32'h0001_0000,
    32'h4002_300C, 32'h4000_0000, FLASH_LAST - 32'h3};
  localparam logic [31:0] RBASE [8] = '{SRAM_BASE, 32'h2000_1F00, UID_BASE,
    FACT_BASE, 32'h4002_1000, 32'h4000_7000, 32'h4002_2F00, FLASH_BASE};

  always #10 mclk = ~mclk;

  sad_decoder sad_decoder_i (
    .i_mclk     (mclk),
    .i_rst      (rst),
    .i_boot_cfg (boot),
    .i_req      (req),
    .i_tgt_rsp  (tgt_rsp),
    .o_tgt      (tgt_req),
    .o_rsp      (rsp)
  );

  sad_target_model sad_target_model_i (
    .i_mclk  (mclk),
    .i_rst   (rst),
    .i_delay (dly),
    .i_tgt   (tgt_req),
    .o_rsp   (tgt_rsp)
  );

  // ==========================================================================
  // helpers
  function automatic logic [31:0] lfsr_next();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  function automatic sad_exp_t expect_of(input logic [31:0] a, input sad_size_t sz);
    sad_exp_t    e;
    int          k;
    logic [31:0] p;
    e = '{routed: 1'b1, tgt: TGT_NONE, err: 1'b0, care: 1'b1};
    // the alias mirrors from its target's base, so past a small target it decodes whatever follows that target
    p = a;
    if (a <= ALIAS_LAST) begin
      p = (boot == BOOT_SYSMEM) ? (SYSMEM_BASE | a) : (boot == BOOT_SRAM) ? (SRAM_BASE | a)
        : (FLASH_BASE | a);
    end
    if (p >= FLASH_BASE && p <= FLASH_LAST) e.tgt = TGT_FLASH;
    else if (p >= SYSMEM_BASE && p <= SYSMEM_LAST) e.tgt = TGT_SYSMEM;
    else if (p >= UID_BASE && p <= UID_LAST) e.tgt = TGT_UID;
    else if (p >= OPTB_BASE && p <= OPTB_LAST) e.tgt = TGT_OPTB;
    else if (p >= FACT_BASE && p <= FACT_LAST) e.tgt = TGT_FACTORY;
    else if (p >= SRAM_BASE && p <= SRAM_LAST) e.tgt = TGT_SRAM;
    else if (p >= APB_BASE && p <= AHB_LAST) begin
      e.tgt = (p <= APB_LAST) ? TGT_APB : TGT_AHB;
      e.routed = 1'b0;
      for (k = 0; k < NUM_PERIPH; k++) begin
        if (p >= PERIPH_BASE[k] && p <= PERIPH_LAST[k]) begin
          e.routed = (sz == SZ_WORD) || (PERIPH_WIDTH[k] == WC_ANY && sz != SZ_BAD)
            || (PERIPH_WIDTH[k] == WC_WORD_HALF && sz == SZ_HALF);
          e.care = e.routed;
        end
      end
      e.err = !e.routed && (e.tgt == TGT_AHB);
    end else begin
      e.routed = 1'b0;
      e.err = 1'b1;
    end
    return e;
  endfunction

  task automatic print_verdict();
    if (n_errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic access(input logic [31:0] a, input logic w, input sad_size_t sz);
    sad_exp_t    e;
    logic        seen;
    sad_target_t st;
    int          n;
    if (abort) return;
    e = expect_of(a, sz);
    seen = 1'b0;
    st = TGT_NONE;
    @(negedge mclk);
    req = '{valid: 1'b1, write: w, size: sz, addr: a, wdata: lfsr_next()};
    for (n = 0; n < 40; n++) begin
      @(posedge mclk);
      #1;
      if (tgt_req.valid === 1'b1) begin
        seen = 1'b1;
        st = tgt_req.target;
      end
      if (rsp.done === 1'b1) break;
    end
    // a hung access stops all further traffic and goes to the verdict
    if (n == 40) begin
      n_errors++;
      abort = 1'b1;
    end else begin
      // routed access reaches its target, reserved access answered without reaching one
      `CHK(seen, e.routed)
      if (e.routed) `CHK(st, e.tgt)
      if (!w) `CHK(rsp.rdata, e.routed ? (32'hC3A5_0000 | {28'h0, e.tgt}) : 32'h0)
      if (e.care) `CHK(rsp.err, e.err)
    end
    @(negedge mclk);
    req.valid = 1'b0;
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    logic [31:0] r;
    rst = 1'b1;
    dly = 2'h0;
    boot = BOOT_FLASH;
    req = '0;
    repeat (10) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    for (int b = 0; b < 3; b++) begin
      boot = sad_boot_t'(b);
      access(32'h0000_0100, 1'b0, SZ_WORD);
      access(ALIAS_LAST - 32'h3, 1'b0, SZ_WORD);
    end
    for (int k = 0; k < 14; k++) begin
      access(CORNER[k], 1'b0, SZ_WORD);
      access(CORNER[k], 1'b1, SZ_WORD);
    end
    for (int s = 0; s < 3; s++) begin
      access(PERIPH_BASE[PERIPH_EXTERNAL_INTERRUPT_CONTROLLER], 1'b0, sad_size_t'(s));
      access(PERIPH_BASE[PERIPH_CLK], 1'b1, sad_size_t'(s));
      access(PERIPH_BASE[PERIPH_PWR], 1'b0, sad_size_t'(s));
      access(PERIPH_BASE[PERIPH_RTC], 1'b0, sad_size_t'(s));
    end
    // random traffic with prompt and slow targets
    for (int i = 0; i < 300; i++) begin
      r = lfsr_next();
      dly = r[19:18];
      boot = sad_boot_t'(r[22:21] == 2'h3 ? 2'h0 : r[22:21]);
      access(RBASE[r[2:0]] + {22'h0, r[11:4], 2'b00}, r[20],
             r[17:16] == 2'h3 ? SZ_WORD : sad_size_t'(r[17:16]));
    end
    print_verdict();
  end
endmodule
